// File: nss_pkg.sv
// Shared constants and types for the NAND strobe sequencer
package nss_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 25000;
  // Least gap from latch release to first read, in half periods
  localparam int ALE_TO_RD_HALF_T = 7;
  localparam int ALE_TO_RD_CYC = (ALE_TO_RD_HALF_T + 1) / 2;
  // Least gap from ready/busy high to read strobe
  localparam int RB_TO_RD_CYC = 3;
  // The read lead cycle supplies the last clock of that gap
  localparam logic [1:0] RB_DLY_LOAD = 2'(RB_TO_RD_CYC - 2);
  localparam logic [3:0] MIN_RECOV_CYC = 4'h2;
  // Write wait-state settings at or below this use the half-period strobe shift
  localparam logic [1:0] WS_HALF_LIMIT = 2'h1;
  localparam logic [1:0] WS_ONE = 2'h1;
  localparam logic [1:0] CNT_ZERO = 2'h0;

  // ****************************************************************
  // Step kinds
  // ****************************************************************
  localparam logic [1:0] OP_CMD_WR = 2'h0;
  localparam logic [1:0] OP_ADDR_WR = 2'h1;
  localparam logic [1:0] OP_DATA_WR = 2'h2;
  localparam logic [1:0] OP_DATA_RD = 2'h3;

  typedef enum logic [10:0] {
    ST_IDLE    = 11'h001,
    ST_RB_WAIT = 11'h002,
    ST_RB_DLY  = 11'h004,
    ST_RD_LEAD = 11'h008,
    ST_RD_ACT  = 11'h010,
    ST_RD_HIGH = 11'h020,
    ST_WR_LEAD = 11'h040,
    ST_WR_ACT  = 11'h080,
    ST_WR_HIGH = 11'h100,
    ST_WR_TAIL = 11'h200,
    ST_SPARE   = 11'h400
  } nss_state_t;

endpackage : nss_pkg

// File: nss_half_shift.sv
// Falling-edge retimer that delays a strobe by half a clock period
`timescale 1ns/10ps
`default_nettype none

module nss_half_shift (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Strobe
  input wire logic level_in,
  input wire logic half_sel,
  output logic level_out
);

  logic half_q_r;

  // Falling-edge copy; cheaper than a doubled clock for one offset
  always_ff @(negedge clock) begin
    if (!rst_n) begin
      half_q_r <= 1'b0;
    end else if (clk_en) begin
      half_q_r <= level_in;
    end
  end

  // Both sources are flops, so the pin stays glitch-free per setting
  assign level_out = half_sel ? half_q_r : level_in;

endmodule : nss_half_shift

`default_nettype wire

// File: nss_skid_buf.sv
// Small flop FIFO holding read bytes while the consumer stalls
`timescale 1ns/10ps
`default_nettype none

module nss_skid_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Occupancy
  output logic [$clog2(DEPTH+1)-1:0] count
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != CW'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign count = count_r;
  assign push = in_valid && in_ready && clk_en;
  assign pop = out_valid && out_ready && clk_en;

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap at DEPTH
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
      end
      if (push && !pop) begin
        count_r <= count_r + CW'(1);
      end else if (pop && !push) begin
        count_r <= count_r - CW'(1);
      end
    end
  end

endmodule : nss_skid_buf

`default_nettype wire

// File: nss_sequencer.sv
// NAND flash strobe sequencer on the second external bus
`timescale 1ns/10ps
`default_nettype none

module nss_sequencer #(
  parameter int TR_NS = 25000,
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Timing configuration
  input wire logic [1:0] access_ws_rd,
  input wire logic [1:0] access_ws_wr,
  input wire logic [3:0] recovery_cycles,
  // Bus sharing
  input wire logic other_master_req,
  input wire logic async_access_busy,
  input wire logic async_lower_byte_lane_low,
  input wire logic async_upper_byte_lane_low,
  // Step requests
  input wire logic step_valid,
  output logic step_ready,
  input wire logic [1:0] step_op,
  input wire logic step_chain,
  input wire logic step_wait_rb,
  input wire logic [7:0] step_wdata,
  // Read data
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  // Status
  output logic seq_busy,
  // Flash pins
  output logic nand_cs_n,
  output logic nand_we_n,
  output logic nand_re_n,
  output logic lower_byte_lane_low,
  output logic upper_byte_lane_low,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic [7:0] data_in,
  input wire logic ready_busy
);

  // ****************************************************************
  // Derived counts
  // ****************************************************************
  localparam int TR_CYC = (TR_NS * 1000 + nss_pkg::CLK_PERIOD_PS - 1) / nss_pkg::CLK_PERIOD_PS;
  localparam int GAP_CYC = TR_CYC + nss_pkg::ALE_TO_RD_CYC;
  localparam int GW = $clog2(GAP_CYC + 1);
  localparam int BCW = $clog2(BUF_DEPTH + 1);

  // Entry state of a new step
  function automatic nss_pkg::nss_state_t entry_of(input logic [1:0] op, input logic wait_rb,
                                                   input logic [1:0] ws_wr,
                                                   input logic after_read);
    if (op == nss_pkg::OP_DATA_RD) begin
      if (wait_rb) begin
        entry_of = nss_pkg::ST_RB_WAIT;
      end else if (after_read) begin
        entry_of = nss_pkg::ST_RD_ACT;
      end else begin
        entry_of = nss_pkg::ST_RD_LEAD;
      end
    end else if (ws_wr > nss_pkg::WS_HALF_LIMIT) begin
      entry_of = nss_pkg::ST_WR_LEAD;
    end else begin
      entry_of = nss_pkg::ST_WR_ACT;
    end
  endfunction : entry_of

  nss_pkg::nss_state_t state_r;
  nss_pkg::nss_state_t state_nxt;
  logic [1:0] cnt_r;
  logic [1:0] op_r;
  logic chain_r;
  logic wrb_r;
  logic [7:0] wdata_r;
  logic [3:0] recov_r;
  logic [GW-1:0] gap_r;
  logic rb_s1_r;
  logic rb_s2_r;
  logic [7:0] din_s1_r;
  logic [7:0] din_s2_r;
  logic [1:0] cap_r;
  logic cs_r;
  logic we_r;
  logic re_r;
  logic ale_r;
  logic cle_r;
  logic own_r;
  logic half_r;
  logic [7:0] dout_r;
  logic doe_r;
  logic we_shift;
  logic [BCW-1:0] buf_count;
  logic buf_in_ready;
  logic sample_now;
  logic room_ok;
  logic idle_ok;
  logic bound_wr;
  logic bound_rd;
  logic take;
  logic [1:0] op_nxt;
  logic [7:0] wdata_nxt;
  logic [2:0] inflight;
  logic [3:0] recov_load;

  // ****************************************************************
  // Admission
  // ****************************************************************
  // Reads in flight are counted so a stalled consumer never overflows
  assign sample_now = (state_r == nss_pkg::ST_RD_ACT) && (cnt_r == nss_pkg::CNT_ZERO);
  assign inflight = 3'(cap_r[0]) + 3'(cap_r[1]) + 3'(sample_now) + 3'(buf_count);
  assign room_ok = (step_op != nss_pkg::OP_DATA_RD) || (inflight < 3'(BUF_DEPTH));
  assign idle_ok = !other_master_req && !async_access_busy && (recov_r == 4'h0);
  assign bound_wr = (state_r == nss_pkg::ST_WR_HIGH);
  assign bound_rd = sample_now;
  always_comb begin
    if (state_r == nss_pkg::ST_IDLE) begin
      take = step_valid && idle_ok && room_ok;
    end else if (bound_wr || bound_rd) begin
      take = chain_r && step_valid && !other_master_req && room_ok;
    end else begin
      take = 1'b0;
    end
  end
  assign step_ready = take && clk_en;
  assign op_nxt = take ? step_op : op_r;
  assign wdata_nxt = take ? step_wdata : wdata_r;

  // ****************************************************************
  // Phase sequencing
  // ****************************************************************
  // Next phase; a plain access spends 2+ws clocks with select low; ready/busy waits and write tails add more
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      nss_pkg::ST_IDLE: begin
        if (take) begin
          state_nxt = entry_of(step_op, step_wait_rb, access_ws_wr, 1'b0);
        end
      end
      nss_pkg::ST_RB_WAIT: begin
        if (rb_s2_r && (gap_r == '0)) begin
          state_nxt = nss_pkg::ST_RB_DLY;
        end
      end
      nss_pkg::ST_RB_DLY: begin
        if (cnt_r == nss_pkg::CNT_ZERO) begin
          state_nxt = nss_pkg::ST_RD_LEAD;
        end
      end
      nss_pkg::ST_RD_LEAD: begin
        state_nxt = nss_pkg::ST_RD_ACT;
      end
      nss_pkg::ST_RD_ACT: begin
        if (cnt_r == nss_pkg::CNT_ZERO) begin
          state_nxt = take ? nss_pkg::ST_RD_HIGH : nss_pkg::ST_IDLE;
        end
      end
      nss_pkg::ST_RD_HIGH: begin
        state_nxt = entry_of(op_r, wrb_r, access_ws_wr, 1'b1);
      end
      nss_pkg::ST_WR_LEAD: begin
        state_nxt = nss_pkg::ST_WR_ACT;
      end
      nss_pkg::ST_WR_ACT: begin
        if (cnt_r == nss_pkg::CNT_ZERO) begin
          state_nxt = nss_pkg::ST_WR_HIGH;
        end
      end
      nss_pkg::ST_WR_HIGH: begin
        if (take) begin
          state_nxt = entry_of(step_op, step_wait_rb, access_ws_wr, 1'b0);
        end else if (access_ws_wr > nss_pkg::WS_HALF_LIMIT) begin
          state_nxt = nss_pkg::ST_WR_TAIL;
        end else begin
          state_nxt = nss_pkg::ST_IDLE;
        end
      end
      nss_pkg::ST_WR_TAIL: begin
        state_nxt = nss_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = nss_pkg::ST_IDLE;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= nss_pkg::ST_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Phase length counter, counts down to zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r <= nss_pkg::CNT_ZERO;
    end else if (clk_en) begin
      if (state_nxt != state_r || state_nxt == nss_pkg::ST_RD_HIGH) begin
        case (state_nxt)
          nss_pkg::ST_WR_ACT: begin
            if (access_ws_wr > nss_pkg::WS_HALF_LIMIT) begin
              cnt_r <= access_ws_wr - nss_pkg::WS_ONE;
            end else begin
              cnt_r <= access_ws_wr;
            end
          end
          nss_pkg::ST_RD_ACT: cnt_r <= access_ws_rd;
          nss_pkg::ST_RB_DLY: cnt_r <= nss_pkg::RB_DLY_LOAD;
          default: cnt_r <= nss_pkg::CNT_ZERO;
        endcase
      end else if (cnt_r != nss_pkg::CNT_ZERO) begin
        cnt_r <= cnt_r - nss_pkg::WS_ONE;
      end
    end
  end

  // Current step
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      op_r <= nss_pkg::OP_CMD_WR;
      chain_r <= 1'b0;
      wrb_r <= 1'b0;
      wdata_r <= 8'h00;
    end else if (clk_en && take) begin
      op_r <= step_op;
      chain_r <= step_chain;
      wrb_r <= step_wait_rb;
      wdata_r <= step_wdata;
    end
  end

  // ****************************************************************
  // Timers and pin synchronisers
  // ****************************************************************
  // Recovery after the shared controller; the floor of two is enforced here
  assign recov_load = (recovery_cycles < nss_pkg::MIN_RECOV_CYC) ?
                      nss_pkg::MIN_RECOV_CYC : recovery_cycles;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      recov_r <= 4'h0;
    end else if (clk_en) begin
      if (async_access_busy) begin
        recov_r <= recov_load;
      end else if (recov_r != 4'h0) begin
        recov_r <= recov_r - 4'h1;
      end
    end
  end

  // Array access gap restarts whenever the address latch is high
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gap_r <= '0;
    end else if (clk_en) begin
      if (ale_r && own_r) begin
        gap_r <= GW'(GAP_CYC);
      end else if (gap_r != '0) begin
        gap_r <= gap_r - GW'(1);
      end
    end
  end

  // Two-flop synchronisers for the flash pins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
      cap_r <= 2'b00;
    end else if (clk_en) begin
      rb_s1_r <= ready_busy;
      rb_s2_r <= rb_s1_r;
      din_s1_r <= data_in;
      din_s2_r <= din_s1_r;
      cap_r <= {cap_r[0], sample_now}; // Push trails the sample by two clocks
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Strobes registered from the next phase so pins change on edges
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_r <= 1'b0;
      we_r <= 1'b0;
      re_r <= 1'b0;
      ale_r <= 1'b0;
      cle_r <= 1'b0;
      own_r <= 1'b0;
      half_r <= 1'b0;
      dout_r <= 8'h00;
      doe_r <= 1'b0;
    end else if (clk_en) begin
      own_r <= (state_nxt != nss_pkg::ST_IDLE);
      cs_r <= (state_nxt != nss_pkg::ST_IDLE);
      we_r <= (state_nxt == nss_pkg::ST_WR_ACT);
      re_r <= (state_nxt == nss_pkg::ST_RD_ACT);
      half_r <= (access_ws_wr <= nss_pkg::WS_HALF_LIMIT);
      // Latches hold through the high phase, low in any read phase
      if (state_nxt == nss_pkg::ST_WR_LEAD || state_nxt == nss_pkg::ST_WR_ACT ||
          state_nxt == nss_pkg::ST_WR_HIGH) begin
        ale_r <= (op_nxt == nss_pkg::OP_ADDR_WR);
        cle_r <= (op_nxt == nss_pkg::OP_CMD_WR);
        doe_r <= 1'b1;
        dout_r <= wdata_nxt;
      end else begin
        ale_r <= 1'b0;
        cle_r <= 1'b0;
        doe_r <= 1'b0;
      end
    end
  end

  // Write strobe shifted half a clock for low wait-state counts
  nss_half_shift u_we_shift (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .level_in(we_r),
    .half_sel(half_r),
    .level_out(we_shift)
  );

  assign nand_cs_n = ~cs_r;
  assign nand_we_n = ~we_shift;
  assign nand_re_n = ~re_r;
  assign lower_byte_lane_low = own_r ? ale_r : async_lower_byte_lane_low;
  assign upper_byte_lane_low = own_r ? cle_r : async_upper_byte_lane_low;
  assign data_out = dout_r;
  assign data_oe_n = ~doe_r;
  assign seq_busy = own_r;

  // ****************************************************************
  // Read buffer
  // ****************************************************************
  nss_skid_buf #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH)
  ) u_rd_buf (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(cap_r[1]),
    .in_ready(buf_in_ready),
    .in_data(din_s2_r),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data),
    .count(buf_count)
  );

endmodule : nss_sequencer

`default_nettype wire

// File: nss_chk_sva.sv
// Pin timing checker for the NAND strobe sequencer
`timescale 1ns/10ps
`default_nettype none
module nss_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Settings and sharing
  input wire logic [1:0] access_ws_rd,
  input wire logic [1:0] access_ws_wr,
  input wire logic other_master_req,
  input wire logic async_access_busy,
  input wire logic async_lower_byte_lane_low,
  // Status and flash pins
  input wire logic seq_busy,
  input wire logic nand_cs_n,
  input wire logic nand_we_n,
  input wire logic nand_re_n,
  input wire logic lower_byte_lane_low,
  input wire logic upper_byte_lane_low,
  input wire logic data_oe_n,
  input wire logic ready_busy
);
  // ****
  // Strobe counters
  // ****
  logic [3:0] re_cnt_r;
  logic [3:0] we_cnt_r;
  logic [3:0] per_r;
  logic we_q_r;
  logic [3:0] we_exp;
  // A half-shifted write strobe still covers whole rising samples
  assign we_exp = (access_ws_wr > 2'h1) ? {2'h0, access_ws_wr} : {2'h0, access_ws_wr} + 4'h1;
  // Low samples of each strobe, and samples between write strobes in one select
  always_ff @(posedge clock) begin
    we_q_r <= nand_we_n;
    re_cnt_r <= (!rst_n || nand_re_n) ? 4'h0 : re_cnt_r + 4'h1;
    we_cnt_r <= (!rst_n || nand_we_n) ? 4'h0 : we_cnt_r + 4'h1;
    if (!rst_n || nand_cs_n) begin
      per_r <= 4'h0;
    end else if (we_q_r && !nand_we_n) begin
      per_r <= 4'h1;
    end else if (per_r != 4'h0) begin
      per_r <= per_r + 4'h1;
    end
  end
  // ****
  // Properties
  // ****
  default clocking dclk @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_re_idle3;
    nand_re_n [*3];
  endsequence
  sequence s_cs_idle3;
    nand_cs_n [*3];
  endsequence
  chk_re_after_cs: assert property (
    $fell(nand_re_n) |-> !$past(nand_cs_n)) else $error("read strobe not led by select");
  chk_re_width: assert property (
    $rose(nand_re_n) |-> re_cnt_r == {2'h0, access_ws_rd} + 4'h1) else $error("read width");
  chk_we_width: assert property (
    $rose(nand_we_n) |-> we_cnt_r == we_exp) else $error("write width");
  chk_wr_cycle: assert property (
    $fell(nand_we_n) && per_r != 4'h0 |-> per_r == {2'h0, access_ws_wr} + 4'h2)
    else $error("write cycle length");
  chk_rb_lead: assert property (
    $rose(ready_busy) |-> s_re_idle3) else $error("read too soon after ready");
  chk_recovery: assert property (
    $fell(async_access_busy) |-> s_cs_idle3) else $error("select inside recovery");
  chk_other_hold: assert property (
    other_master_req && nand_cs_n |=> nand_cs_n) else $error("start while bus wanted");
  chk_latch_lead: assert property (
    $fell(nand_re_n) |-> !$past(lower_byte_lane_low) && !$past(upper_byte_lane_low))
    else $error("latch high before read");
  chk_lane_pass: assert property (
    !seq_busy |-> lower_byte_lane_low == async_lower_byte_lane_low) else $error("lane mux");
  // Read lead cycle keeps the read strobe off for two samples after a write
  chk_wr_to_rd: assert property (
    $rose(nand_we_n) |-> nand_re_n ##1 nand_re_n) else $error("read too close to write");
  chk_wr_tail: assert property (
    $rose(nand_we_n) && access_ws_wr > 2'h1 |-> !nand_cs_n ##1 !nand_cs_n)
    else $error("select released early after write");
  chk_wr_drive: assert property (
    !nand_we_n |-> !data_oe_n) else $error("data not driven during write");
endmodule : nss_chk
bind nss_sequencer nss_chk u_chk (.clock(clock), .rst_n(rst_n), .access_ws_rd(access_ws_rd),
  .access_ws_wr(access_ws_wr), .other_master_req(other_master_req),
  .async_access_busy(async_access_busy), .async_lower_byte_lane_low(async_lower_byte_lane_low),
  .seq_busy(seq_busy), .nand_cs_n(nand_cs_n), .nand_we_n(nand_we_n), .nand_re_n(nand_re_n),
  .lower_byte_lane_low(lower_byte_lane_low), .upper_byte_lane_low(upper_byte_lane_low),
  .data_oe_n(data_oe_n), .ready_busy(ready_busy));
`default_nettype wire

// File: nss_flash_model.sv
// Behavioural NAND flash on the far side of the strobe sequencer
`timescale 1ns/10ps
`default_nettype none
module nss_flash_model #(
  parameter logic [7:0] CONFIRM_CMD = 8'h5A,
  parameter int BUSY_CYC = 30
) (
  // Clock
  input wire logic clock,
  // Strobes and latches
  input wire logic nand_cs_n,
  input wire logic nand_we_n,
  input wire logic nand_re_n,
  input wire logic lower_byte_lane_low,
  input wire logic upper_byte_lane_low,
  // Data and status
  input wire logic [7:0] data_out,
  output logic [7:0] data_in,
  output logic ready_busy
);
  // ****
  // Array state
  // ****
  logic [7:0] cmd_r = 8'h00;
  logic [7:0] addr_r = 8'h00;
  logic [7:0] wdata_r = 8'h00;
  logic [7:0] idx_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  int busy_cnt = 0;
  // Bytes latch on the rising write strobe; the latch pins pick the kind
  always @(posedge nand_we_n) begin
    if (!nand_cs_n && upper_byte_lane_low) begin
      cmd_r <= data_out;
      idx_r <= 8'h00;
      if (data_out == CONFIRM_CMD) busy_cnt <= BUSY_CYC;
    end else if (!nand_cs_n && lower_byte_lane_low) begin
      addr_r <= data_out;
    end else if (!nand_cs_n) begin
      wdata_r <= data_out;
    end
  end
  // Each finished read moves on to the next byte
  always @(posedge nand_re_n) begin
    last_r <= cmd_r + idx_r;
    idx_r <= idx_r + 8'h01;
  end
  // Array access time after the confirm command
  always @(posedge clock) begin
    if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
  end
  assign ready_busy = (busy_cnt == 0);
  // No valid byte while busy or released, so a stale value never matches
  assign data_in = (!nand_cs_n && !nand_re_n && ready_busy) ? cmd_r + idx_r : ~last_r;
endmodule : nss_flash_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the NAND strobe sequencer with a flash model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ****
  // Signals
  // ****
  localparam logic [7:0] CONFIRM = 8'h5A;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic other_master_req = 1'b0;
  logic async_access_busy = 1'b0;
  logic async_lo = 1'b0;
  logic async_up = 1'b0;
  logic step_valid = 1'b0;
  logic step_chain = 1'b0;
  logic step_wait_rb = 1'b0;
  logic rd_ready = 1'b0;
  logic [1:0] access_ws_rd = 2'h0;
  logic [1:0] access_ws_wr = 2'h0;
  logic [1:0] step_op = 2'h0;
  logic [3:0] recovery_cycles = 4'h2;
  logic [7:0] step_wdata = 8'h00;
  logic step_ready, rd_valid, seq_busy, nand_cs_n, nand_we_n, nand_re_n;
  logic ale, cle, data_oe_n, ready_busy;
  logic [7:0] rd_data, data_out, data_in;
  int fail_count = 0;
  int samples_checked = 0;
  // 40 MHz clock
  initial forever #12.5 clock = ~clock;
  nss_sequencer #(.TR_NS(100), .BUF_DEPTH(2)) dut (
    .clock(clock), .rst_n(rst_n), .clk_en(1'b1), .access_ws_rd(access_ws_rd),
    .access_ws_wr(access_ws_wr), .recovery_cycles(recovery_cycles),
    .other_master_req(other_master_req), .async_access_busy(async_access_busy),
    .async_lower_byte_lane_low(async_lo), .async_upper_byte_lane_low(async_up),
    .step_valid(step_valid), .step_ready(step_ready), .step_op(step_op),
    .step_chain(step_chain), .step_wait_rb(step_wait_rb), .step_wdata(step_wdata),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .seq_busy(seq_busy),
    .nand_cs_n(nand_cs_n), .nand_we_n(nand_we_n), .nand_re_n(nand_re_n),
    .lower_byte_lane_low(ale), .upper_byte_lane_low(cle), .data_out(data_out),
    .data_oe_n(data_oe_n), .data_in(data_in), .ready_busy(ready_busy));
  nss_flash_model #(.CONFIRM_CMD(CONFIRM), .BUSY_CYC(30)) u_flash (
    .clock(clock), .nand_cs_n(nand_cs_n), .nand_we_n(nand_we_n), .nand_re_n(nand_re_n),
    .lower_byte_lane_low(ale), .upper_byte_lane_low(cle), .data_out(data_out),
    .data_in(data_in), .ready_busy(ready_busy));
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Offer a step and hold it until taken; the caller drops valid
  task automatic step(input logic [1:0] op, input logic ch, input logic wrb, input logic [7:0] wd);
    int n = 0;
    step_valid <= 1'b1;
    step_op <= op;
    step_chain <= ch;
    step_wait_rb <= wrb;
    step_wdata <= wd;
    do begin
      @(negedge clock);
      n++;
    end while (step_ready !== 1'b1 && n < 3000);
    check(8'(step_ready), 8'h01, "step_ready");
    @(posedge clock);
  endtask : step
  // Release the consumer for cnt bytes, which must count up from first
  task automatic pop_n(input logic [7:0] first, input int cnt);
    int n;
    rd_ready <= 1'b1;
    for (int i = 0; i < cnt; i++) begin
      n = 0;
      do begin
        @(negedge clock);
        n++;
      end while (rd_valid !== 1'b1 && n < 3000);
      check(8'(rd_valid), 8'h01, "rd_valid");
      check(rd_data, first + 8'(i), "rd_data");
      @(posedge clock);
    end
    rd_ready <= 1'b0;
  endtask : pop_n
  // Offer a single read that must not be taken for cyc cycles
  task automatic refused(input int cyc, input string what);
    int n = 0;
    step_valid <= 1'b1;
    step_op <= 2'h3;
    step_chain <= 1'b0;
    repeat (cyc) begin
      @(negedge clock);
      n += int'(step_ready === 1'b1);
    end
    check(8'(n), 8'h00, what);
    @(posedge clock);
    step_valid <= 1'b0;
  endtask : refused
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // ****
  // Scenarios
  // ****
  task automatic t_writes;
    for (int ws = 0; ws < 4; ws++) begin
      access_ws_wr <= 2'(ws);
      step(2'h0, 1'b1, 1'b0, 8'hA0 + 8'(ws));
      step(2'h1, 1'b1, 1'b0, 8'h10 + 8'(ws));
      step(2'h2, 1'b0, 1'b0, 8'hC0 + 8'(ws));
      step_valid <= 1'b0;
      repeat (8) @(posedge clock);
      check(u_flash.cmd_r, 8'hA0 + 8'(ws), "cmd");
      check(u_flash.addr_r, 8'h10 + 8'(ws), "addr");
      check(u_flash.wdata_r, 8'hC0 + 8'(ws), "wdata");
      check(8'(data_oe_n), 8'h01, "bus_release");
    end
    $display("writes done");
  endtask : t_writes
  // Status and ID chains at every wait-state setting
  task automatic t_cmd_reads;
    for (int ws = 0; ws < 4; ws++) begin
      access_ws_rd <= 2'(ws);
      access_ws_wr <= 2'(ws);
      step(2'h0, 1'b1, 1'b0, 8'h70);
      step(2'h3, 1'b0, 1'b0, 8'h00);
      step_valid <= 1'b0;
      pop_n(8'h70, 1);
      step(2'h0, 1'b1, 1'b0, 8'h90);
      step(2'h1, 1'b1, 1'b0, 8'h00);
      step(2'h3, 1'b1, 1'b0, 8'h00);
      step(2'h3, 1'b0, 1'b0, 8'h00);
      step_valid <= 1'b0;
      pop_n(8'h90, 2);
    end
    $display("command reads done");
  endtask : t_cmd_reads
  // Array busy after confirm; reads wait for ready
  task automatic t_wait;
    access_ws_rd <= 2'h1;
    step(2'h0, 1'b1, 1'b0, 8'h00);
    step(2'h1, 1'b1, 1'b0, 8'h07);
    step(2'h0, 1'b0, 1'b0, CONFIRM);
    step(2'h3, 1'b1, 1'b1, 8'h00);
    step(2'h3, 1'b0, 1'b0, 8'h00);
    step_valid <= 1'b0;
    pop_n(CONFIRM, 2);
    $display("busy wait done");
  endtask : t_wait
  // Consumer stalls: the buffer fills, further reads wait, nothing is lost
  task automatic t_stall;
    access_ws_rd <= 2'h0;
    step(2'h0, 1'b1, 1'b0, 8'h44);
    step(2'h3, 1'b1, 1'b0, 8'h00);
    step(2'h3, 1'b0, 1'b0, 8'h00);
    refused(20, "full_buffer");
    pop_n(8'h44, 2);
    $display("stall done");
  endtask : t_stall
  // Shared controller access, recovery, and a competing master
  task automatic t_share;
    async_access_busy <= 1'b1;
    async_lo <= 1'b1;
    async_up <= 1'b1;
    recovery_cycles <= 4'h3;
    repeat (3) @(posedge clock);
    check(8'(ale), 8'h01, "lower_lane");
    check(8'(cle), 8'h01, "upper_lane");
    check(8'(seq_busy), 8'h00, "seq_busy");
    async_access_busy <= 1'b0;
    async_lo <= 1'b0;
    async_up <= 1'b0;
    step(2'h0, 1'b1, 1'b0, 8'h66);
    step(2'h3, 1'b0, 1'b0, 8'h00);
    step_valid <= 1'b0;
    pop_n(8'h66, 1);
    other_master_req <= 1'b1;
    refused(12, "other_master");
    other_master_req <= 1'b0;
    $display("sharing done");
  endtask : t_share
  // Reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_writes();
    t_cmd_reads();
    t_wait();
    t_stall();
    t_share();
    repeat (4) @(posedge clock);
    test_done();
  end
  // Generous bound on the whole run; a hang ends as a failure
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
